// *** include/ranging_pkg.sv ***
package ranging_pkg;
  // arbitrary default, strap-free device address
  localparam logic [6:0] DEV_ADDR = 7'h40;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int NCFG = 22;
  localparam int IX_PULSE = 0, IX_SYM_THR = 1, IX_INT_THR = 2;
  localparam int IX_MAX_SPOT = 3, IX_MIN_SPOT = 4, IX_SCALE = 5;
  localparam int IX_MEDIAN = 6, IX_COMP_LO = 7, IX_COMP_HI = 8;
  localparam int IX_COMP_EN = 9, IX_INT_SEL = 10, IX_ACCUM = 11;
  localparam int IX_CHK_INT = 12, IX_CHK_MIN = 13, IX_CHK_MAX = 14;
  localparam int IX_CHK_SYM = 15, IX_FUSE_ASSIGN = 16, IX_PROG_EN = 17;
  localparam int IX_FUSE_TARGET = 18, IX_PROG_DATA = 19;
  localparam int IX_POWER = 20, IX_CLK_SEL = 21;
  localparam logic [7:0] CFG_ADDR [NCFG] = '{
    8'h13, 8'h1C, 8'h2F, 8'h33, 8'h34, 8'h35, 8'h3F, 8'h8D, 8'h8E, 8'h8F,
    8'h90, 8'hA8, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hC9, 8'hCA, 8'hCB, 8'hCD,
    8'hE8, 8'hEC};
  localparam logic [7:0] CFG_MASK [NCFG] = '{
    8'h07, 8'h1F, 8'h7F, 8'hFF, 8'h7F, 8'h07, 8'h30, 8'hFC, 8'h1F, 8'h03,
    8'h1F, 8'h03, 8'h01, 8'h01, 8'h01, 8'h01, 8'hFF, 8'h01, 8'h3F, 8'hFF,
    8'h01, 8'hFF};
  localparam logic [7:0] CFG_RST [NCFG] = '{
    8'h07, 8'h0E, 8'h00, 8'h7F, 8'h00, 8'h02, 8'h30, 8'h00, 8'h00, 8'h03,
    8'h00, 8'h03, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};
  localparam logic [7:0] ADDR_SCRATCH = 8'h4C;
  localparam logic [7:0] ADDR_DIST_HI = 8'h5E;
  localparam logic [7:0] ADDR_DIST_LO = 8'h5F;
  localparam logic [7:0] ADDR_EXP_HI = 8'h64;
  localparam logic [7:0] ADDR_EXP_LO = 8'h65;
  localparam logic [7:0] ADDR_GAIN = 8'h67;
  localparam logic [7:0] ADDR_INT_BYTE = 8'h91;
  localparam logic [7:0] ADDR_FUSE_CTL = 8'hC8;
  localparam logic [7:0] ADDR_SOFT_RST = 8'hEE;
  localparam logic [7:0] ADDR_BANK = 8'hEF;
  localparam logic [7:0] ADDR_RIGHT = 8'hF8;
  localparam logic [7:0] ADDR_LEFT = 8'hF9;
  localparam logic [7:0] ADDR_PEAK = 8'hFA;
  localparam int FUSE_LOAD_BIT = 6;
  localparam int FUSE_DIS_BIT = 7;
  localparam int SCRATCH_BIT = 4;
  localparam logic SOFT_RST_FUSE_DIS = 1'b1;
  localparam logic [7:0] SOFT_RST_CODE = 8'h06;
  localparam logic [7:0] MANUAL_CLK = 8'hFF;
  localparam logic [7:0] INT_SEL_LOW = 8'h10;
  localparam logic [7:0] INT_SEL_MID = 8'h11;
  localparam logic [7:0] INT_SEL_HIGH = 8'h12;
  localparam logic [1:0] BANK_DIGITAL = 2'h0;
  localparam logic [1:0] BANK_FUSE = 2'h3;
  localparam logic [1:0] COMP_EN_ON = 2'h2;
  localparam int FUSE_BANKS = 5;
  localparam int FUSE_BANK_BITS = 64;
  localparam int FUSE_BITS = FUSE_BANKS * FUSE_BANK_BITS;
  localparam int FUSE_MAP_BYTES = FUSE_BITS / 8;
  localparam logic [8:0] PULSE_US_TBL [8] = '{
    9'h000, 9'h000, 9'h000, 9'h028, 9'h050, 9'h0A0, 9'h0F0, 9'h140};
  localparam logic [4:0] ACCUM_TBL [4] = '{5'h01, 5'h05, 5'h1E, 5'h0A};
  localparam logic [3:0] MEDIAN_TBL [4] = '{4'h7, 4'h5, 4'h9, 4'h1};
  localparam logic [8:0] FULL_SCALE_BASE = 9'h100;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } port_state_t;
endpackage : ranging_pkg

// *** include/reg_access_if.sv ***
`timescale 1ns/1ps
interface reg_access_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output wr_en, output addr, output wdata, input rdata);
  modport slave (input wr_en, input addr, input wdata, output rdata);
endinterface : reg_access_if

// *** verilog/serial_reg_port.sv ***
`timescale 1ns/1ps
module serial_reg_port (
  input wire logic clk_sys_in, // system clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic scl_in, // serial clock pin
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // serial data drive value
  output logic sda_oe_b_out, // low while pulling data low
  reg_access_if.master bus // register side
);
  import ranging_pkg::*;
  logic scl_s1_q, scl_s2_q, scl_prev_q;
  logic sda_s1_q, sda_s2_q, sda_prev_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  port_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, ptr_q;
  logic rw_q, drive_q, wr_q, nack_q;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_prev_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_prev_q <= sda_s2_q;
    end
  end

  assign scl_rise = scl_s2_q & ~scl_prev_q;
  assign scl_fall = ~scl_s2_q & scl_prev_q;
  assign start_det = scl_s2_q & scl_prev_q & sda_prev_q & ~sda_s2_q;
  assign stop_det = scl_s2_q & scl_prev_q & ~sda_prev_q & sda_s2_q;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      drive_q <= 1'b0;
      wr_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (start_det) begin
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        drive_q <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        drive_q <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_REG, ST_WDATA: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s2_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == BYTE_BITS) begin
              cnt_q <= 4'h0;
              drive_q <= 1'b1;
              if (state_q == ST_ADDR) begin
                if (sh_q[7:1] == DEV_ADDR) begin
                  rw_q <= sh_q[0];
                  state_q <= ST_ADDR_ACK;
                end else begin
                  drive_q <= 1'b0;
                  state_q <= ST_IDLE;
                end
              end else if (state_q == ST_REG) begin
                ptr_q <= sh_q;
                state_q <= ST_REG_ACK;
              end else begin
                wr_q <= 1'b1;
                state_q <= ST_WDATA_ACK;
              end
            end
          end
          ST_ADDR_ACK, ST_RDATA_ACK: begin
            if (scl_rise) begin
              nack_q <= sda_s2_q;
            end else if (scl_fall) begin
              if (state_q == ST_ADDR_ACK && !rw_q) begin
                drive_q <= 1'b0;
                state_q <= ST_REG;
              end else if (state_q == ST_RDATA_ACK && nack_q) begin
                state_q <= ST_IDLE;
              end else begin
                // byte captured at the fall, pointer then moves on
                sh_q <= bus.rdata;
                drive_q <= ~bus.rdata[7];
                ptr_q <= ptr_q + 8'h01;
                cnt_q <= 4'h1;
                state_q <= ST_RDATA;
              end
            end
          end
          ST_REG_ACK, ST_WDATA_ACK: begin
            if (scl_fall) begin
              drive_q <= 1'b0;
              if (state_q == ST_WDATA_ACK) begin
                ptr_q <= ptr_q + 8'h01;
              end
              state_q <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (cnt_q == BYTE_BITS) begin
                drive_q <= 1'b0;
                cnt_q <= 4'h0;
                state_q <= ST_RDATA_ACK;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                drive_q <= ~sh_q[6];
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          default: begin
            drive_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_b_out = ~drive_q;
  assign bus.wr_en = wr_q;
  assign bus.addr = ptr_q;
  assign bus.wdata = sh_q;
endmodule : serial_reg_port

// *** verilog/ranging_sensor_config_regs.sv ***
`timescale 1ns/1ps
// What this block does
// - pulse width code 7..3 gives 320,240,160,80,40 us; resets to 7.
// - 12-bit distance read as high eight bits and low four bits.
// - scaling 1 means 128 cm full range, 2 means 64 cm; resets 2.
// - median bits 5:4 pick 7,5,9,1 samples; reset pattern 11.
// - compensation is high five bits times 64 plus low six bits.
// - intensity select 0x10/11/12 reads low/middle/high byte; reset 0.
// - accumulation code 0,1,2,3 means 1,5,30,10; resets to 3.
// - fuse target address is six bits, one of 64 positions.
// - bit 6 copies fuses into the mapped bank; bit 7 high disables.
// - fuse assign holds bit number high nibble, bank low nibble.
// - bank nibble 1 to 5 selects fuse groups first to fifth.
// - right and left edges readable; spot size is right minus left.
// - peak readable; symmetry is abs of size minus twice peak.
// - intensity and min spot thresholds power up from fuse values.
// - low compensation part is shifted right two before combining.
// - bank select 0x00 reaches digital bank, 0x03 the fuse bank.
module ranging_sensor_config_regs (
  input wire logic clk_sys_in, // 250 MHz system clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic scl_in, // serial clock pin
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // serial data drive value
  output logic sda_oe_b_out, // low while driving data
  input wire logic [11:0] range_raw_in, // measured distance
  input wire logic [15:0] exposure_value_in, // exposure
  input wire logic [7:0] gain_value_in, // gain
  input wire logic [23:0] intensity_in, // signal intensity
  input wire logic [7:0] spot_right_in, // right edge coordinate
  input wire logic [7:0] spot_left_in, // left edge coordinate
  input wire logic [7:0] spot_peak_in, // peak coordinate
  input wire logic [ranging_pkg::FUSE_BITS-1:0] fuse_bits_in, // fuses
  input wire logic [6:0] fuse_intensity_thr_in, // per-unit value
  input wire logic [6:0] fuse_min_spot_thr_in, // per-unit value
  output logic [8:0] emit_pulse_us_out, // pulse width in us
  output logic [4:0] accum_count_out, // measurements per output
  output logic [3:0] median_samples_out, // median window
  output logic [8:0] full_scale_cm_out, // reportable range in cm
  output logic [10:0] comp_coeff_out, // compensation coefficient
  output logic comp_enable_out, // compensation on
  output logic [6:0] intensity_thr_out, // intensity threshold
  output logic [6:0] min_spot_thr_out, // min spot threshold
  output logic [7:0] max_spot_thr_out, // max spot threshold
  output logic [4:0] symmetry_thr_out, // symmetry threshold
  output logic [3:0] check_disable_out, // sym,max,min,intensity
  output logic standby_out, // stand-by requested
  output logic manual_clock_out, // manual clock selected
  output logic scratch_access_out, // one-cycle access pulse
  output logic fuse_prog_enable_out, // fuse programming on
  output logic [3:0] fuse_prog_bank_out, // fuse group 1..5
  output logic [3:0] fuse_prog_bit_out, // bit number
  output logic [5:0] fuse_prog_addr_out, // target position
  output logic [7:0] fuse_prog_data_out, // program data
  output logic [8:0] spot_size_out, // right minus left, signed
  output logic [9:0] spot_symmetry_out // symmetry magnitude
);
  import ranging_pkg::*;

  reg_access_if bus ();
  logic [7:0] cfg_q [NCFG];
  logic [7:0] init_val [NCFG];
  logic [7:0] fuse_map_q [FUSE_MAP_BYTES];
  logic [1:0] bank_q;
  logic fuse_dis_q, fuse_load_q, soft_rst_q, init_q;
  logic dig_wr, reinit;
  logic [11:0] dist_q;
  logic [10:0] sym_d;

  serial_reg_port u_port (
    .clk_sys_in (clk_sys_in),
    .rst_b_in (rst_b_in),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .sda_out (sda_out),
    .sda_oe_b_out (sda_oe_b_out),
    .bus (bus.master)
  );

  // bank select stays reachable from both banks so the host can return
  assign dig_wr = bus.wr_en && bank_q != BANK_FUSE;
  assign reinit = !init_q || soft_rst_q;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      init_q <= 1'b0;
      soft_rst_q <= 1'b0;
      scratch_access_out <= 1'b0;
    end else begin
      init_q <= 1'b1;
      soft_rst_q <= dig_wr && bus.addr == ADDR_SOFT_RST &&
                    bus.wdata == SOFT_RST_CODE;
      scratch_access_out <= dig_wr && bus.addr == ADDR_SCRATCH &&
                            bus.wdata[SCRATCH_BIT];
    end
  end

  always_comb begin
    for (int i = 0; i < NCFG; i++) begin
      init_val[i] = CFG_RST[i];
    end
    init_val[IX_INT_THR] = {1'b0, fuse_intensity_thr_in};
    init_val[IX_MIN_SPOT] = {1'b0, fuse_min_spot_thr_in};
  end

  // masked storage keeps undocumented bits at zero
  for (genvar gi = 0; gi < NCFG; gi++) begin : g_cfg
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        cfg_q[gi] <= CFG_RST[gi];
      end else if (reinit) begin
        cfg_q[gi] <= init_val[gi];
      end else if (dig_wr && bus.addr == CFG_ADDR[gi]) begin
        cfg_q[gi] <= bus.wdata & CFG_MASK[gi];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bank_q <= BANK_DIGITAL;
      fuse_dis_q <= SOFT_RST_FUSE_DIS;
      fuse_load_q <= 1'b0;
    end else if (soft_rst_q) begin
      bank_q <= BANK_DIGITAL;
      fuse_dis_q <= SOFT_RST_FUSE_DIS;
      fuse_load_q <= 1'b0;
    end else begin
      if (bus.wr_en && bus.addr == ADDR_BANK) begin
        bank_q <= bus.wdata[1:0];
      end
      // load bit self-clears; only the gate bit is stored
      fuse_load_q <= dig_wr && bus.addr == ADDR_FUSE_CTL &&
                     bus.wdata[FUSE_LOAD_BIT] &&
                     !bus.wdata[FUSE_DIS_BIT];
      if (dig_wr && bus.addr == ADDR_FUSE_CTL) begin
        fuse_dis_q <= bus.wdata[FUSE_DIS_BIT];
      end
    end
  end

  for (genvar gb = 0; gb < FUSE_MAP_BYTES; gb++) begin : g_fuse
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        fuse_map_q[gb] <= 8'h00;
      end else if (fuse_load_q) begin
        fuse_map_q[gb] <= fuse_bits_in[FUSE_BITS-1-8*gb -: 8];
      end
    end
  end

  // readouts sampled each cycle; host reads the two halves apart,
  // so a moving target may tear between them
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dist_q <= 12'h000;
      spot_size_out <= 9'h000;
      spot_symmetry_out <= 10'h000;
    end else begin
      dist_q <= range_raw_in;
      spot_size_out <= {1'b0, spot_right_in} -
                       {1'b0, spot_left_in};
      spot_symmetry_out <= sym_d[10] ? 10'(-sym_d) : sym_d[9:0];
    end
  end

  assign sym_d = {{2{spot_size_out[8]}}, spot_size_out} -
                 {2'b00, spot_peak_in, 1'b0};

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      emit_pulse_us_out <= PULSE_US_TBL[CFG_RST[IX_PULSE][2:0]];
      accum_count_out <= ACCUM_TBL[CFG_RST[IX_ACCUM][1:0]];
      median_samples_out <= MEDIAN_TBL[CFG_RST[IX_MEDIAN][5:4]];
      full_scale_cm_out <= FULL_SCALE_BASE >> CFG_RST[IX_SCALE][2:0];
      comp_coeff_out <= 11'h000;
      comp_enable_out <= 1'b0;
      intensity_thr_out <= 7'h00;
      min_spot_thr_out <= 7'h00;
      max_spot_thr_out <= CFG_RST[IX_MAX_SPOT];
      symmetry_thr_out <= CFG_RST[IX_SYM_THR][4:0];
      check_disable_out <= 4'h4;
      standby_out <= 1'b0;
      manual_clock_out <= 1'b0;
      fuse_prog_enable_out <= 1'b0;
      fuse_prog_bank_out <= 4'h0;
      fuse_prog_bit_out <= 4'h0;
      fuse_prog_addr_out <= 6'h00;
      fuse_prog_data_out <= 8'h00;
    end else begin
      emit_pulse_us_out <= PULSE_US_TBL[cfg_q[IX_PULSE][2:0]];
      accum_count_out <= ACCUM_TBL[cfg_q[IX_ACCUM][1:0]];
      median_samples_out <= MEDIAN_TBL[cfg_q[IX_MEDIAN][5:4]];
      full_scale_cm_out <= FULL_SCALE_BASE >> cfg_q[IX_SCALE][2:0];
      comp_coeff_out <= {cfg_q[IX_COMP_HI][4:0],
                         cfg_q[IX_COMP_LO][7:2]};
      comp_enable_out <= cfg_q[IX_COMP_EN][1:0] == COMP_EN_ON;
      intensity_thr_out <= cfg_q[IX_INT_THR][6:0];
      min_spot_thr_out <= cfg_q[IX_MIN_SPOT][6:0];
      max_spot_thr_out <= cfg_q[IX_MAX_SPOT];
      symmetry_thr_out <= cfg_q[IX_SYM_THR][4:0];
      check_disable_out <= {cfg_q[IX_CHK_SYM][0], cfg_q[IX_CHK_MAX][0],
                            cfg_q[IX_CHK_MIN][0], cfg_q[IX_CHK_INT][0]};
      standby_out <= cfg_q[IX_POWER][0];
      manual_clock_out <= cfg_q[IX_CLK_SEL] == MANUAL_CLK;
      fuse_prog_enable_out <= cfg_q[IX_PROG_EN][0];
      fuse_prog_bank_out <= cfg_q[IX_FUSE_ASSIGN][3:0];
      fuse_prog_bit_out <= cfg_q[IX_FUSE_ASSIGN][7:4];
      fuse_prog_addr_out <= cfg_q[IX_FUSE_TARGET][5:0];
      fuse_prog_data_out <= cfg_q[IX_PROG_DATA];
    end
  end

  always_comb begin
    bus.rdata = 8'h00;
    if (bus.addr == ADDR_BANK) begin
      bus.rdata = {6'h00, bank_q};
    end else if (bank_q == BANK_FUSE) begin
      if (bus.addr < 8'(FUSE_MAP_BYTES)) begin
        bus.rdata = fuse_map_q[bus.addr[5:0]];
      end
    end else if (bus.addr == ADDR_FUSE_CTL) begin
      bus.rdata = {fuse_dis_q, 7'h00};
    end else if (bus.addr == ADDR_DIST_HI) begin
      bus.rdata = dist_q[11:4];
    end else if (bus.addr == ADDR_DIST_LO) begin
      bus.rdata = {4'h0, dist_q[3:0]};
    end else if (bus.addr == ADDR_EXP_HI && manual_clock_out) begin
      bus.rdata = exposure_value_in[15:8];
    end else if (bus.addr == ADDR_EXP_LO && manual_clock_out) begin
      bus.rdata = exposure_value_in[7:0];
    end else if (bus.addr == ADDR_GAIN && manual_clock_out) begin
      bus.rdata = gain_value_in;
    end else if (bus.addr == ADDR_INT_BYTE) begin
      if (cfg_q[IX_INT_SEL] == INT_SEL_LOW) begin
        bus.rdata = intensity_in[7:0];
      end else if (cfg_q[IX_INT_SEL] == INT_SEL_MID) begin
        bus.rdata = intensity_in[15:8];
      end else if (cfg_q[IX_INT_SEL] == INT_SEL_HIGH) begin
        bus.rdata = intensity_in[23:16];
      end
    end else if (bus.addr == ADDR_RIGHT) begin
      bus.rdata = spot_right_in;
    end else if (bus.addr == ADDR_LEFT) begin
      bus.rdata = spot_left_in;
    end else if (bus.addr == ADDR_PEAK) begin
      bus.rdata = spot_peak_in;
    end else begin
      for (int i = 0; i < NCFG; i++) begin
        if (bus.addr == CFG_ADDR[i]) begin
          bus.rdata = cfg_q[i];
        end
      end
    end
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_cfg_wr(int ix, logic [7:0] v);
    dig_wr && bus.addr == CFG_ADDR[ix] && bus.wdata == v && init_q;
  endsequence

  sequence s_fuse_load;
    dig_wr && bus.addr == ADDR_FUSE_CTL && bus.wdata == 8'h40 && init_q;
  endsequence

  chk_pulse_width: assert property (
    s_cfg_wr(IX_PULSE, 8'h03) |-> ##2 emit_pulse_us_out == 9'h028)
    else $error("pulse width decode wrong");

  chk_dist_split: assert property (
    (bank_q == BANK_DIGITAL && bus.addr == ADDR_DIST_HI) |->
    bus.rdata == $past(range_raw_in[11:4]))
    else $error("distance high byte wrong");

  chk_full_scale: assert property (
    s_cfg_wr(IX_SCALE, 8'h01) |-> ##2 full_scale_cm_out == 9'h080)
    else $error("full scale decode wrong");

  chk_median_window: assert property (
    s_cfg_wr(IX_MEDIAN, 8'h20) |-> ##2 median_samples_out == 4'h9)
    else $error("median window decode wrong");

  chk_comp_coeff: assert property (
    init_q |=> comp_coeff_out == 11'(64 * $past(cfg_q[IX_COMP_HI][4:0]) +
                                    ($past(cfg_q[IX_COMP_LO]) >> 2)))
    else $error("compensation coefficient wrong");

  chk_accum_count: assert property (
    s_cfg_wr(IX_ACCUM, 8'h02) |-> ##2 accum_count_out == 5'h1E)
    else $error("accumulation decode wrong");

  chk_fuse_load: assert property (
    s_fuse_load |-> ##2
    fuse_map_q[FUSE_MAP_BYTES-1] == $past(fuse_bits_in[7:0], 1))
    else $error("fuse bank not copied");

  chk_fuse_gate: assert property (
    (dig_wr && bus.addr == ADDR_FUSE_CTL && bus.wdata[FUSE_DIS_BIT])
    |=> !fuse_load_q ##1 $stable(fuse_map_q[0]))
    else $error("fuse copied while disabled");

  chk_bank_steer: assert property (
    (bank_q == BANK_FUSE && bus.addr == 8'h20) |->
    bus.rdata == fuse_map_q[32])
    else $error("fuse bank not steered");

  chk_spot_size: assert property (
    init_q |-> spot_size_out ==
    9'(int'($past(spot_right_in)) - int'($past(spot_left_in))))
    else $error("spot size wrong");

  chk_reserved_zero: assert property (
    (dig_wr && bus.addr == CFG_ADDR[IX_SYM_THR] && init_q) |=>
    cfg_q[IX_SYM_THR] == ($past(bus.wdata) & 8'h1F))
    else $error("reserved bits stored");

  chk_thr_from_fuse: assert property (
    $rose(init_q) |->
    cfg_q[IX_INT_THR] == {1'b0, $past(fuse_intensity_thr_in)})
    else $error("threshold not taken from fuse");
endmodule : ranging_sensor_config_regs

// *** verif/host_model.sv ***
`timescale 1ns/1ps
module host_model
  import ranging_pkg::*;
(
  input wire logic clk_sys_in, // bench clock
  input wire logic sda_oe_b_in, // device pulls data low when 0
  output logic scl_out, // serial clock
  output logic sda_out // host data, 1 releases the pull-up
);
  logic [7:0] rx_q;
  event got;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // 8 clocks per phase keeps scl well clear of the 2-flop sync
  task automatic tick();
    repeat (8) @(negedge clk_sys_in);
  endtask : tick
  task automatic start();
    sda_out = 1'b1;
    tick();
    scl_out = 1'b1;
    tick();
    sda_out = 1'b0;
    tick();
    scl_out = 1'b0;
    tick();
  endtask : start
  task automatic stop();
    sda_out = 1'b0;
    tick();
    scl_out = 1'b1;
    tick();
    sda_out = 1'b1;
    tick();
  endtask : stop
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_out = d[i];
      tick();
      scl_out = 1'b1;
      tick();
      q[i] = sda_out & sda_oe_b_in;
      scl_out = 1'b0;
      tick();
    end
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [8:0] q;
    start();
    xfer({DEV_ADDR, 2'b01}, q);
    xfer({a, 1'b1}, q);
    xfer({v, 1'b1}, q);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic [8:0] q;
    start();
    xfer({DEV_ADDR, 2'b01}, q);
    xfer({a, 1'b1}, q);
    start();
    xfer({DEV_ADDR, 2'b11}, q);
    // last byte, so nack it
    xfer(9'h1FF, q);
    rx_q = q[8:1];
    stop();
    ->got;
  endtask : rd
endmodule : host_model

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import ranging_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic scl, hsda, oe_b;
  logic [11:0] rng;
  logic [15:0] expo;
  logic [7:0] gain, rt, lt, pk;
  logic [23:0] inten;
  logic [319:0] fuse;
  logic [6:0] fi, fm;
  logic [7:0] wd [NCFG];
  logic [8:0] pus, fs, ssz;
  logic [4:0] acc;
  logic [3:0] med, fbit, fbank;
  logic [10:0] cc;
  logic [9:0] ssym;
  logic [5:0] faddr;
  logic cen, sby, mclk, fpe, sacc;
  logic [6:0] ith, mth;
  logic [7:0] xth, fpd;
  logic [4:0] sth;
  logic [3:0] cdis;
  int scr_n = 0;
  logic [15:0] pw [5] = '{16'h28, 16'h50, 16'hA0, 16'hF0, 16'h140};
  logic [15:0] ac [4] = '{16'h1, 16'h5, 16'h1E, 16'hA};
  logic [15:0] md [4] = '{16'h7, 16'h5, 16'h9, 16'h1};
  logic [15:0] exp_q [$];
  int bad_count = 0, check_count = 0, cyc = 0, sz, sy;
  int seed = 32'hB626;
  always #2 clk = ~clk;
  host_model host_u (.clk_sys_in(clk), .sda_oe_b_in(oe_b), .scl_out(scl),
    .sda_out(hsda));
  ranging_sensor_config_regs dut_u (.clk_sys_in(clk), .rst_b_in(rst_b),
    .scl_in(scl), .sda_in(hsda & oe_b), .sda_out(), .sda_oe_b_out(oe_b),
    .range_raw_in(rng), .exposure_value_in(expo), .gain_value_in(gain),
    .intensity_in(inten), .spot_right_in(rt), .spot_left_in(lt),
    .spot_peak_in(pk), .fuse_bits_in(fuse), .fuse_intensity_thr_in(fi),
    .fuse_min_spot_thr_in(fm), .emit_pulse_us_out(pus),
    .accum_count_out(acc), .median_samples_out(med),
    .full_scale_cm_out(fs), .comp_coeff_out(cc), .comp_enable_out(cen),
    .intensity_thr_out(ith), .min_spot_thr_out(mth),
    .max_spot_thr_out(xth), .symmetry_thr_out(sth),
    .check_disable_out(cdis), .standby_out(sby),
    .manual_clock_out(mclk), .scratch_access_out(sacc),
    .fuse_prog_enable_out(fpe), .fuse_prog_bank_out(fbank),
    .fuse_prog_bit_out(fbit), .fuse_prog_addr_out(faddr),
    .fuse_prog_data_out(fpd), .spot_size_out(ssz),
    .spot_symmetry_out(ssym));
  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask : cmp
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({8'h00, e});
    host_u.rd(a);
  endtask : chk
  always @(host_u.got) cmp(exp_q.pop_front(), {8'h00, host_u.rx_q});
  // one-cycle pulse, counted away from the launching edge
  always @(negedge clk) scr_n += sacc;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    {rng, expo, gain, rt} = {$random(seed), $random(seed)};
    {inten, lt, pk, fi, fm} = {$random(seed), $random(seed)};
    fuse = {10{$random(seed)}};
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    for (int i = 0; i < NCFG; i++) chk(CFG_ADDR[i], (i == IX_INT_THR) ?
      {1'b0, fi} : (i == IX_MIN_SPOT) ? {1'b0, fm} : CFG_RST[i]);
    $display("reset values done");
    for (int i = 0; i < NCFG; i++) begin
      wd[i] = $random(seed);
      host_u.wr(CFG_ADDR[i], wd[i]);
    end
    for (int i = 0; i < NCFG; i++) chk(CFG_ADDR[i], wd[i] & CFG_MASK[i]);
    cmp({wd[IX_COMP_HI][4:0], wd[IX_COMP_LO][7:2]}, cc);
    cmp(wd[IX_FUSE_ASSIGN], {fbit, fbank});
    cmp(wd[IX_FUSE_TARGET][5:0], faddr);
    cmp(wd[IX_INT_THR][6:0], ith);
    cmp(wd[IX_MIN_SPOT][6:0], mth);
    cmp(wd[IX_MAX_SPOT], xth);
    cmp(wd[IX_SYM_THR][4:0], sth);
    for (int i = 0; i < 4; i++) cmp(wd[IX_CHK_INT + i][0], cdis[i]);
    cmp(wd[IX_COMP_EN][1:0] == 2'h2, cen);
    cmp(wd[IX_POWER][0], sby);
    cmp(wd[IX_PROG_EN][0], fpe);
    cmp(wd[IX_CLK_SEL] == MANUAL_CLK, mclk);
    cmp(wd[IX_PROG_DATA], fpd);
    $display("read back done");
    for (int k = 0; k < 5; k++) begin
      host_u.wr(8'h13, 8'(k + 3));
      cmp(pw[k], pus);
    end
    for (int k = 0; k < 4; k++) begin
      host_u.wr(8'hA8, 8'(k));
      cmp(ac[k], acc);
      host_u.wr(8'h3F, 8'(k << 4));
      cmp(md[k], med);
    end
    host_u.wr(8'h35, 8'h01);
    cmp(16'h80, fs);
    chk(ADDR_DIST_HI, rng[11:4]);
    chk(ADDR_DIST_LO, {4'h0, rng[3:0]});
    host_u.wr(8'hEC, MANUAL_CLK);
    chk(ADDR_EXP_HI, expo[15:8]);
    chk(ADDR_GAIN, gain);
    for (int k = 0; k < 3; k++) begin
      host_u.wr(8'h90, 8'(8'h10 + k));
      chk(ADDR_INT_BYTE, inten[8 * k +: 8]);
    end
    chk(ADDR_RIGHT, rt);
    sz = int'(rt) - int'(lt);
    sy = (sz - 2 * int'(pk) < 0) ? 2 * int'(pk) - sz : sz - 2 * int'(pk);
    cmp(sz[8:0], ssz);
    cmp(sy[9:0], ssym);
    host_u.wr(ADDR_FUSE_CTL, 8'h40);
    host_u.wr(ADDR_BANK, 8'h03);
    chk(8'h20, fuse[63:56]);
    host_u.wr(ADDR_BANK, 8'h00);
    chk(ADDR_BANK, 8'h00);
    host_u.wr(ADDR_FUSE_CTL, 8'hC0);
    chk(ADDR_FUSE_CTL, 8'h80);
    chk(ADDR_LEFT, lt);
    chk(ADDR_PEAK, pk);
    host_u.wr(ADDR_SCRATCH, 8'h10);
    cmp(1, scr_n);
    host_u.wr(ADDR_SOFT_RST, SOFT_RST_CODE);
    chk(CFG_ADDR[IX_INT_THR], {1'b0, fi});
    $display("decode tests done");
    complete_run();
  end
endmodule : testbench
